// ---- inc/tcp_pkg.sv ----
/*
 * Shared constants and carrier types of the timer control block:
 * register indices and byte addresses, field positions, reset values,
 * timing counts, pin action codes and the APB request and answer types.
 * Assumes a 32-bit APB with 12-bit byte addresses, one word per register.
 */
package tcp_pkg;

	// bus widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	////////////////////////////////////////////////////////////////////////
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_PIN_ACTION   = 8'h20;
	localparam logic [7:0] IDX_CC_ENABLE    = 8'h22;
	localparam logic [7:0] IDX_CC_FLAGS     = 8'h23;
	localparam logic [7:0] IDX_OVF_ENABLE   = 8'h24;
	localparam logic [7:0] IDX_OVF_FLAGS    = 8'h25;
	localparam logic [7:0] IDX_ACCUM_CTRL   = 8'h26;
	localparam logic [7:0] IDX_MODE_CONFIG  = 8'h28;

	// byte addresses derived from the indices
	localparam logic [ADDR_W-1:0] ADDR_PIN_ACTION  = {2'b00, IDX_PIN_ACTION, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CC_ENABLE   = {2'b00, IDX_CC_ENABLE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CC_FLAGS    = {2'b00, IDX_CC_FLAGS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_OVF_ENABLE  = {2'b00, IDX_OVF_ENABLE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_OVF_FLAGS   = {2'b00, IDX_OVF_FLAGS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_ACCUM_CTRL  = {2'b00, IDX_ACCUM_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MODE_CONFIG = {2'b00, IDX_MODE_CONFIG, 2'b00};

	////////////////////////////////////////////////////////////////////////
	// reset value shared by every register of the block
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// compare/capture flag register: bit 3 is the shared channel
	localparam int unsigned CC_SHARED_BIT = 3;

	// overflow/periodic enable and flag register fields
	localparam int unsigned OVF_BIT       = 7;
	localparam int unsigned PERIODIC_BIT  = 6;
	localparam int unsigned ACC_OVF_BIT   = 5;
	localparam int unsigned ACC_EDGE_BIT  = 4;
	localparam int unsigned PRESCALE_LSB  = 0;
	localparam logic [7:0]  OVF_EN_MASK   = 8'hF0;
	localparam logic [7:0]  OVF_FLAG_MASK = 8'hF0;

	// accumulator control fields
	localparam int unsigned ACC_EN_BIT      = 6;
	localparam int unsigned ACC_MODE_BIT    = 5;
	localparam int unsigned ACC_POL_BIT     = 4;
	localparam int unsigned SEL_C4_BIT      = 2;
	localparam int unsigned RATE_LSB        = 0;
	localparam logic [7:0]  ACCUM_CTRL_MASK = 8'h77;

	// mode config: bit 0 set lifts the write-once prescaler lock
	localparam int unsigned SPECIAL_MODE_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// timing counts in core clock cycles
	localparam logic [6:0] PRESCALE_WINDOW_CYCLES = 7'h40;
	localparam int unsigned PERIODIC_BASE_CYCLES  = 8192;

	// prescaler terminal counts for divide by 1, 4, 8, 16
	localparam logic [3:0] PRE_TC_DIV1  = 4'h0;
	localparam logic [3:0] PRE_TC_DIV4  = 4'h3;
	localparam logic [3:0] PRE_TC_DIV8  = 4'h7;
	localparam logic [3:0] PRE_TC_DIV16 = 4'hF;

	// compare pin action codes, mode bit high, level bit low
	typedef enum logic [1:0] {
		ACT_DISCONNECT = 2'b00,
		ACT_TOGGLE     = 2'b01,
		ACT_CLEAR      = 2'b10,
		ACT_SET        = 2'b11
	} tcp_action_t;

	// write-once lock of the prescaler field
	typedef enum logic {
		LOCK_OPEN = 1'b0,
		LOCK_SHUT = 1'b1
	} tcp_lock_t;

	// APB request as driven by the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} tcp_apb_req_t;

	// APB answer of the slave
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} tcp_apb_rsp_t;

endpackage

// ---- logic/tcp_periodic_gen.sv ----
/*
 * Free-running periodic timeout generator.
 * Assumes a synchronous active-high reset on the same clock; the rate
 * select comes from a register on that clock.
 */
`timescale 1ns/1ps

module tcp_periodic_gen #(
	parameter int unsigned BASE_CYCLES = tcp_pkg::PERIODIC_BASE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] rate,
	output logic            timeout
);
	import tcp_pkg::*;

	logic [16:0] count; // cycles since the last timeout
	logic [16:0] last;  // final count of the selected period

	// period is the base doubled once per rate step
	always_comb begin
		case (rate)
			2'b00:   last = 17'(BASE_CYCLES - 1);
			2'b01:   last = 17'(2 * BASE_CYCLES - 1);
			2'b10:   last = 17'(4 * BASE_CYCLES - 1);
			default: last = 17'(8 * BASE_CYCLES - 1);
		endcase
	end

	// runs without pause; only reset restarts the count, so the first
	// timeout comes one whole period after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			count   <= 17'h0_0000;
			timeout <= 1'b0;
		end else if (count >= last) begin
			// >= so a rate cut mid-period still ends at once
			count   <= 17'h0_0000;
			timeout <= 1'b1;
		end else begin
			count   <= count + 17'h0_0001;
			timeout <= 1'b0;
		end
	end

endmodule

// ---- logic/tcp_timer_ctrl.sv ----
/*
 * Control and status of a 16-bit free-running timer: compare pin
 * actions for channels 2 to 5, compare/capture and overflow/periodic
 * enables and flags, write-once prescaler and periodic interrupt.
 * Assumes compare matches, capture edges and accumulator events arrive
 * as one-cycle pulses from logic on CORE_CLK; registers sit on APB.
 */
`timescale 1ns/1ps

module tcp_timer_ctrl #(
	parameter int unsigned PERIODIC_CYCLES = tcp_pkg::PERIODIC_BASE_CYCLES
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RESET,
	input  wire tcp_pkg::tcp_apb_req_t APB_REQ,
	output tcp_pkg::tcp_apb_rsp_t      APB_RSP,
	input  wire logic [4:0]            COMPARE_MATCH,
	input  wire logic [3:0]            CAPTURE_EVENT,
	input  wire logic                  ACCUM_OVERFLOW_EVENT,
	input  wire logic                  ACCUM_EDGE_EVENT,
	output logic [15:0]                COUNTER_VALUE,
	output logic                       PRESCALE_TICK,
	output logic [3:0]                 COMPARE_PIN_LEVEL,
	output logic [3:0]                 COMPARE_PIN_DRIVE,
	output logic [2:0]                 ACCUM_CONTROL,
	output logic                       CAPTURE4_SELECT,
	output logic                       COMPARE_CAPTURE_IRQ,
	output logic                       OVERFLOW_IRQ,
	output logic                       PERIODIC_IRQ,
	output logic                       ACCUM_IRQ
);
	import tcp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers and internal state

	logic [7:0]  compare_pin_action_ctrl;           // mode/level pairs
	logic [7:0]  compare_capture_irq_enable;        // one per flag
	logic [7:0]  compare_capture_event_flags;       // sticky events
	logic [7:0]  overflow_periodic_enable_prescale; // enables + divider
	logic [7:0]  overflow_periodic_event_flags;     // sticky events
	logic [7:0]  pulse_accumulator_control;         // accum, select, rate
	logic        special_mode;                      // lifts write-once
	tcp_lock_t   prescale_lock;                     // prescaler lock
	logic [6:0]  window_count;                      // cycles since reset
	logic [3:0]  pre_count;                         // prescaler divider
	logic [3:0]  pre_tc;                            // divider end value
	logic        periodic_timeout;                  // one-cycle pulse
	logic        capture4_compare5_select;          // shared channel use
	logic [1:0]  periodic_rate_select;              // periodic rate
	logic [1:0]  prescale_select;                   // counter divider

	// bus decode
	logic        setup_phase;  // first cycle of a transfer
	logic        wr_take;      // write takes effect this edge
	logic        hit_mapped;   // address is one of ours
	logic [7:0]  wdata;        // low byte of write data
	logic [7:0]  rd_byte;      // read mux output
	logic        prescale_ok;  // prescaler write allowed now

	// flag update terms
	logic [7:0]  cc_set;       // compare/capture set pulses
	logic [7:0]  cc_clear;     // software clear mask
	logic [7:0]  next_cc_flags;
	logic [7:0]  ovf_set;
	logic [7:0]  ovf_clear;
	logic [7:0]  next_ovf_flags;
	logic        counter_wrap; // counter passes from all ones to zero

	assign capture4_compare5_select =
		pulse_accumulator_control[SEL_C4_BIT];
	assign periodic_rate_select =
		pulse_accumulator_control[RATE_LSB +: 2];
	assign prescale_select =
		overflow_periodic_enable_prescale[PRESCALE_LSB +: 2];

	////////////////////////////////////////////////////////////////////////
	// APB decode

	assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
	// pready is high in every access phase, so access plus psel suffices
	assign wr_take = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready
		& APB_REQ.pwrite;
	assign wdata = APB_REQ.pwdata[7:0];

	// mapped address check, also used for the error answer
	always_comb begin
		case (APB_REQ.paddr)
			ADDR_PIN_ACTION,
			ADDR_CC_ENABLE,
			ADDR_CC_FLAGS,
			ADDR_OVF_ENABLE,
			ADDR_OVF_FLAGS,
			ADDR_ACCUM_CTRL,
			ADDR_MODE_CONFIG: hit_mapped = 1'b1;
			default:          hit_mapped = 1'b0;
		endcase
	end

	// read mux; unused upper bits and reserved bits read zero
	always_comb begin
		case (APB_REQ.paddr)
			ADDR_PIN_ACTION:  rd_byte = compare_pin_action_ctrl;
			ADDR_CC_ENABLE:   rd_byte = compare_capture_irq_enable;
			ADDR_CC_FLAGS:    rd_byte = compare_capture_event_flags;
			ADDR_OVF_ENABLE:  rd_byte = overflow_periodic_enable_prescale;
			ADDR_OVF_FLAGS:   rd_byte = overflow_periodic_event_flags;
			ADDR_ACCUM_CTRL:  rd_byte = pulse_accumulator_control;
			ADDR_MODE_CONFIG: rd_byte = {7'h00, special_mode};
			default:          rd_byte = 8'h00;
		endcase
	end

	// answer: ready and data are loaded in the setup cycle, so every
	// transfer completes in its first access cycle with no wait state
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			APB_RSP.pready  <= 1'b0;
			APB_RSP.pslverr <= 1'b0;
			APB_RSP.prdata  <= 32'h0000_0000;
		end else begin
			APB_RSP.pready  <= setup_phase;
			APB_RSP.pslverr <= setup_phase & ~hit_mapped;
			if (setup_phase & ~APB_REQ.pwrite) begin
				APB_RSP.prdata <= {24'h00_0000, rd_byte};
			end else begin
				APB_RSP.prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// plain control registers

	// pin action pairs, enables and accumulator control
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			compare_pin_action_ctrl    <= RESET_BYTE;
			compare_capture_irq_enable <= RESET_BYTE;
			pulse_accumulator_control  <= RESET_BYTE;
			special_mode               <= 1'b0;
		end else if (wr_take) begin
			case (APB_REQ.paddr)
				ADDR_PIN_ACTION:
					compare_pin_action_ctrl <= wdata;
				ADDR_CC_ENABLE:
					compare_capture_irq_enable <= wdata;
				ADDR_ACCUM_CTRL:
					pulse_accumulator_control <=
						wdata & ACCUM_CTRL_MASK;
				ADDR_MODE_CONFIG:
					special_mode <= wdata[SPECIAL_MODE_BIT];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-once prescaler

	// normal mode allows one write, only inside the window after reset;
	// a late or second write still updates the enable bits
	assign prescale_ok = special_mode
		| ((prescale_lock == LOCK_OPEN)
		& (window_count < PRESCALE_WINDOW_CYCLES));

	// window counter saturates once the window has passed
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			window_count <= 7'h00;
		end else if (window_count < PRESCALE_WINDOW_CYCLES) begin
			window_count <= window_count + 7'h01;
		end
	end

	// lock shuts on the first write, never reopens until reset
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			prescale_lock <= LOCK_OPEN;
		end else begin
			case (prescale_lock)
				LOCK_OPEN: begin
					if (wr_take & (APB_REQ.paddr == ADDR_OVF_ENABLE)) begin
						prescale_lock <= LOCK_SHUT;
					end
				end
				LOCK_SHUT: prescale_lock <= LOCK_SHUT;
				default:   prescale_lock <= LOCK_SHUT;
			endcase
		end
	end

	// enable bits 7..4, bits 3..2 held zero, prescaler gated by the lock
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			overflow_periodic_enable_prescale <= RESET_BYTE;
		end else if (wr_take & (APB_REQ.paddr == ADDR_OVF_ENABLE)) begin
			overflow_periodic_enable_prescale[7:4] <=
				wdata[7:4] & OVF_EN_MASK[7:4];
			overflow_periodic_enable_prescale[3:2] <= 2'b00;
			if (prescale_ok) begin
				overflow_periodic_enable_prescale[1:0] <=
					wdata[PRESCALE_LSB +: 2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler and free-running counter

	// divider end value per select code
	always_comb begin
		case (prescale_select)
			2'b00:   pre_tc = PRE_TC_DIV1;
			2'b01:   pre_tc = PRE_TC_DIV4;
			2'b10:   pre_tc = PRE_TC_DIV8;
			default: pre_tc = PRE_TC_DIV16;
		endcase
	end

	// >= keeps the divider safe if the select shrinks mid-count
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pre_count     <= 4'h0;
			PRESCALE_TICK <= 1'b0;
		end else if (pre_count >= pre_tc) begin
			pre_count     <= 4'h0;
			PRESCALE_TICK <= 1'b1;
		end else begin
			pre_count     <= pre_count + 4'h1;
			PRESCALE_TICK <= 1'b0;
		end
	end

	assign counter_wrap = PRESCALE_TICK & (COUNTER_VALUE == 16'hFFFF);

	// counter advances one step per prescaler tick
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			COUNTER_VALUE <= 16'h0000;
		end else if (PRESCALE_TICK) begin
			COUNTER_VALUE <= COUNTER_VALUE + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// periodic interrupt divider

	tcp_periodic_gen #(
		.BASE_CYCLES (PERIODIC_CYCLES)
	) u_periodic (
		.clk     (CORE_CLK),
		.reset   (RESET),
		.rate    (periodic_rate_select),
		.timeout (periodic_timeout)
	);

	////////////////////////////////////////////////////////////////////////
	// event flags

	// compare/capture set pulses in register bit order
	always_comb begin
		cc_set = 8'h00;
		cc_set[7] = COMPARE_MATCH[0];
		cc_set[6] = COMPARE_MATCH[1];
		cc_set[5] = COMPARE_MATCH[2];
		cc_set[4] = COMPARE_MATCH[3];
		// shared bit follows whichever function is selected
		cc_set[CC_SHARED_BIT] = capture4_compare5_select
			? CAPTURE_EVENT[3] : COMPARE_MATCH[4];
		cc_set[2] = CAPTURE_EVENT[0];
		cc_set[1] = CAPTURE_EVENT[1];
		cc_set[0] = CAPTURE_EVENT[2];
	end

	// ones clear, zeros leave alone; a same-cycle event wins
	assign cc_clear = (wr_take & (APB_REQ.paddr == ADDR_CC_FLAGS))
		? wdata : 8'h00;
	assign next_cc_flags = (compare_capture_event_flags & ~cc_clear)
		| cc_set;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			compare_capture_event_flags <= RESET_BYTE;
		end else begin
			compare_capture_event_flags <= next_cc_flags;
		end
	end

	// overflow/periodic set pulses; low nibble never sets
	always_comb begin
		ovf_set = 8'h00;
		ovf_set[OVF_BIT]      = counter_wrap;
		ovf_set[PERIODIC_BIT] = periodic_timeout;
		ovf_set[ACC_OVF_BIT]  = ACCUM_OVERFLOW_EVENT;
		ovf_set[ACC_EDGE_BIT] = ACCUM_EDGE_EVENT;
	end

	assign ovf_clear = (wr_take & (APB_REQ.paddr == ADDR_OVF_FLAGS))
		? wdata : 8'h00;
	assign next_ovf_flags = ((overflow_periodic_event_flags & ~ovf_clear)
		| ovf_set) & OVF_FLAG_MASK;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			overflow_periodic_event_flags <= RESET_BYTE;
		end else begin
			overflow_periodic_event_flags <= next_ovf_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt requests, registered from flags and enables

	// the shared enable bit gates whichever function owns bit 3
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			COMPARE_CAPTURE_IRQ <= 1'b0;
			OVERFLOW_IRQ        <= 1'b0;
			PERIODIC_IRQ        <= 1'b0;
			ACCUM_IRQ           <= 1'b0;
		end else begin
			COMPARE_CAPTURE_IRQ <= |(compare_capture_event_flags
				& compare_capture_irq_enable);
			OVERFLOW_IRQ <= overflow_periodic_event_flags[OVF_BIT]
				& overflow_periodic_enable_prescale[OVF_BIT];
			PERIODIC_IRQ <= overflow_periodic_event_flags[PERIODIC_BIT]
				& overflow_periodic_enable_prescale[PERIODIC_BIT];
			ACCUM_IRQ <= (overflow_periodic_event_flags[ACC_OVF_BIT]
				& overflow_periodic_enable_prescale[ACC_OVF_BIT])
				| (overflow_periodic_event_flags[ACC_EDGE_BIT]
				& overflow_periodic_enable_prescale[ACC_EDGE_BIT]);
		end
	end

	// accumulator setup and shared channel select to neighbours
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ACCUM_CONTROL   <= 3'b000;
			CAPTURE4_SELECT <= 1'b0;
		end else begin
			ACCUM_CONTROL <= {pulse_accumulator_control[ACC_EN_BIT],
				pulse_accumulator_control[ACC_MODE_BIT],
				pulse_accumulator_control[ACC_POL_BIT]};
			CAPTURE4_SELECT <= capture4_compare5_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare pin actions, channels 2..5 as index 0..3

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_pin
			tcp_action_t action; // pair for this channel
			logic        active; // channel owns its pin
			logic        fire;   // match that acts on the pin

			assign action = tcp_action_t'(
				compare_pin_action_ctrl[7-2*ch -: 2]);
			// channel five loses its pin to capture four
			assign active = (ch != 3) | ~capture4_compare5_select;
			assign fire = COMPARE_MATCH[ch+1] & active;

			// level changes only on a qualifying match
			always_ff @(posedge CORE_CLK) begin
				if (RESET) begin
					COMPARE_PIN_LEVEL[ch] <= 1'b0;
				end else if (fire) begin
					case (action)
						ACT_TOGGLE: COMPARE_PIN_LEVEL[ch] <=
							~COMPARE_PIN_LEVEL[ch];
						ACT_CLEAR:  COMPARE_PIN_LEVEL[ch] <= 1'b0;
						ACT_SET:    COMPARE_PIN_LEVEL[ch] <= 1'b1;
						default:    ; // disconnected: level held
					endcase
				end
			end

			// timer drives the pin unless disconnected or not selected
			always_ff @(posedge CORE_CLK) begin
				if (RESET) begin
					COMPARE_PIN_DRIVE[ch] <= 1'b0;
				end else begin
					COMPARE_PIN_DRIVE[ch] <=
						(action != ACT_DISCONNECT) & active;
				end
			end
		end
	endgenerate

endmodule

// ---- tb/tcp_timer_checker.sv ----
/* port checker of the timer control block.
   bound onto tcp_timer_ctrl; one clock, synchronous reset. */
`timescale 1ns/1ps
module tcp_timer_checker (
	input wire logic                  CORE_CLK,
	input wire logic                  RESET,
	input wire tcp_pkg::tcp_apb_req_t APB_REQ,
	input wire tcp_pkg::tcp_apb_rsp_t APB_RSP,
	input wire logic [4:0]            COMPARE_MATCH,
	input wire logic [3:0]            CAPTURE_EVENT,
	input wire logic [15:0]           COUNTER_VALUE,
	input wire logic                  PRESCALE_TICK,
	input wire logic [3:0]            COMPARE_PIN_LEVEL,
	input wire logic [3:0]            COMPARE_PIN_DRIVE,
	input wire logic                  CAPTURE4_SELECT,
	input wire logic                  COMPARE_CAPTURE_IRQ,
	input wire logic                  OVERFLOW_IRQ,
	input wire logic                  PERIODIC_IRQ,
	input wire logic                  ACCUM_IRQ
);
	import tcp_pkg::*;
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	// anything that may raise the compare/capture request
	logic cc_cause;
	assign cc_cause = |COMPARE_MATCH || |CAPTURE_EVENT || APB_REQ.penable;
	////////////////////////////////////////////////////////////////////////
	// apb steps: setup, then answered access
	sequence s_setup;
		APB_REQ.psel && !APB_REQ.penable;
	endsequence
	sequence s_access;
		APB_REQ.penable && APB_RSP.pready;
	endsequence
	apb_answer_a: assert property (s_setup |=> s_access)
		else $error("no answer in access cycle");
	ready_in_access_a: assert property (APB_RSP.pready |-> s_access)
		else $error("ready outside access");
	reset_quiet_a: assert property (
		$past(RESET) |-> !COMPARE_CAPTURE_IRQ && !OVERFLOW_IRQ
		&& !PERIODIC_IRQ && !ACCUM_IRQ && COMPARE_PIN_DRIVE == 4'h0)
		else $error("outputs not quiet after reset");
	// channel two pin moves only after its own match
	pin_hold_a: assert property (
		!$past(COMPARE_MATCH[1]) |-> $stable(COMPARE_PIN_LEVEL[0]))
		else $error("pin moved without match");
	ch5_released_a: assert property (
		CAPTURE4_SELECT && $past(CAPTURE4_SELECT)
		|-> !COMPARE_PIN_DRIVE[3])
		else $error("channel five driven while capture selected");
	count_hold_a: assert property (
		!$past(PRESCALE_TICK) |-> $stable(COUNTER_VALUE))
		else $error("counter moved without tick");
	count_step_a: assert property (
		$past(PRESCALE_TICK)
		|-> COUNTER_VALUE == $past(COUNTER_VALUE) + 16'h0001)
		else $error("counter did not step by one");
	// request rises two cycles after an event or an enable write
	irq_cause_a: assert property (
		$rose(COMPARE_CAPTURE_IRQ) |-> $past(cc_cause, 2))
		else $error("request without cause");
endmodule
bind tcp_timer_ctrl tcp_timer_checker i_tcp_timer_checker (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.COMPARE_MATCH(COMPARE_MATCH), .CAPTURE_EVENT(CAPTURE_EVENT),
	.COUNTER_VALUE(COUNTER_VALUE), .PRESCALE_TICK(PRESCALE_TICK),
	.COMPARE_PIN_LEVEL(COMPARE_PIN_LEVEL), .COMPARE_PIN_DRIVE(COMPARE_PIN_DRIVE),
	.CAPTURE4_SELECT(CAPTURE4_SELECT), .COMPARE_CAPTURE_IRQ(COMPARE_CAPTURE_IRQ),
	.OVERFLOW_IRQ(OVERFLOW_IRQ), .PERIODIC_IRQ(PERIODIC_IRQ), .ACCUM_IRQ(ACCUM_IRQ));

// ---- tb/tcp_timer_ctrl_bench.sv ----
/* bench of the timer control block: apb tasks, event pulses, checks.
   assumes the package and the bound port checker. */
`timescale 1ns/1ps
module tcp_timer_ctrl_bench;
	import tcp_pkg::*;
	localparam int unsigned PRD = 16; // short periodic base
	logic         core_clk = 1'b0;
	logic         reset = 1'b1;
	tcp_apb_req_t req = '0;
	tcp_apb_rsp_t rsp;
	logic [4:0]   match = '0;
	logic [3:0]   capt = '0;
	logic [1:0]   acc_ev = '0;  // overflow, edge
	logic [15:0]  cnt;
	logic [3:0]   lvl;
	logic [3:0]   drv;
	logic [2:0]   accum;
	logic         tick, sel4, cc_irq, ovf_irq, prd_irq, acc_irq;
	logic [31:0]  rdq;          // last read data
	logic         rde;          // last error answer
	int           error_cnt = 0;
	int           checks_done = 0;
	int           cyc = 0;      // free cycle count
	int           n, t1;
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;
	tcp_timer_ctrl #(.PERIODIC_CYCLES(PRD)) i_tcp_timer_ctrl (
		.CORE_CLK(core_clk), .RESET(reset), .APB_REQ(req), .APB_RSP(rsp),
		.COMPARE_MATCH(match), .CAPTURE_EVENT(capt),
		.ACCUM_OVERFLOW_EVENT(acc_ev[1]), .ACCUM_EDGE_EVENT(acc_ev[0]),
		.COUNTER_VALUE(cnt), .PRESCALE_TICK(tick), .COMPARE_PIN_LEVEL(lvl),
		.COMPARE_PIN_DRIVE(drv), .ACCUM_CONTROL(accum), .CAPTURE4_SELECT(sel4),
		.COMPARE_CAPTURE_IRQ(cc_irq), .OVERFLOW_IRQ(ovf_irq),
		.PERIODIC_IRQ(prd_irq), .ACCUM_IRQ(acc_irq));
	////////////////////////////////////////////////////////////////////////
	// closing report, the single exit
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// seen value first, expected value second
	task automatic chk(input string nm, input logic [31:0] g,
		input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one apb transfer; two idle edges after it let outputs settle
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int k;
		k = 0;
		req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 20);
		rdq = rsp.prdata;
		rde = rsp.pslverr;
		req <= '0;
		repeat (2) @(posedge core_clk);
		if (k >= 20) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	// read and compare the masked low byte; upper bits must be zero
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [7:0] e, input logic [7:0] m);
		xfer(1'b0, a, 8'h00);
		chk(nm, rdq & {24'hFF_FFFF, m}, {24'h00_0000, e});
	endtask
	// one-cycle event pulses, then two edges for flag and request
	task automatic pulse(input logic [4:0] m, input logic [3:0] c,
		input logic [1:0] a);
		match <= m;
		capt <= c;
		acc_ev <= a;
		@(posedge core_clk);
		match <= '0;
		capt <= '0;
		acc_ev <= '0;
		repeat (2) @(posedge core_clk);
	endtask
	// bounded wait: 0 tick, 1 periodic request, 2 counter at maximum
	task automatic wait_hi(input int s, input int lim);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(s == 0 ? tick === 1'b1 : s == 1 ? prd_irq === 1'b1
			: cnt === 16'hFFFF) && n < lim);
		if (n >= lim) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		rdc("action rst", ADDR_PIN_ACTION, 8'h00, 8'hFF);
		rdc("cc en rst", ADDR_CC_ENABLE, 8'h00, 8'hFF);
		rdc("cc flag rst", ADDR_CC_FLAGS, 8'h00, 8'hFF);
		rdc("ovf en rst", ADDR_OVF_ENABLE, 8'h00, 8'hFF);
		// setup lands on the same edge that sets the first timeout flag, so it reads zero
		rdc("prd first", ADDR_OVF_FLAGS, 8'h00, 8'hFF);
		rdc("accum rst", ADDR_ACCUM_CTRL, 8'h00, 8'hFF);
		chk("rst outs", {drv, cc_irq, ovf_irq, prd_irq, acc_irq}, 32'h0);
		// prescaler inside the window, then a refused second write
		xfer(1'b1, ADDR_OVF_ENABLE, 8'hFD);
		rdc("ovf en", ADDR_OVF_ENABLE, 8'hF1, 8'hFF);
		xfer(1'b1, ADDR_OVF_ENABLE, 8'hF3);
		rdc("lock", ADDR_OVF_ENABLE, 8'hF1, 8'hFF);
		wait_hi(0, 40);
		wait_hi(0, 40);
		chk("tick gap", n, 32'h0000_0004);
		xfer(1'b0, 12'h0FC, 8'h00);
		chk("unmapped", {rde, rdq[30:0]}, 32'h8000_0000);
		// pin actions: toggle, clear, set, toggle
		xfer(1'b1, ADDR_PIN_ACTION, 8'h6D);
		pulse(5'h1E, 4'h0, 2'h0);
		chk("pins", {drv, lvl}, 32'h0000_00FD);
		rdc("cc flags", ADDR_CC_FLAGS, 8'h78, 8'hFF);
		xfer(1'b1, ADDR_ACCUM_CTRL, 8'h75);
		pulse(5'h1E, 4'h0, 2'h0);
		chk("pins sel", {accum, sel4, drv, lvl}, 32'h0F7C);
		rdc("accum", ADDR_ACCUM_CTRL, 8'h75, 8'hFF);
		xfer(1'b1, ADDR_CC_FLAGS, 8'h08);
		rdc("clear one", ADDR_CC_FLAGS, 8'h70, 8'hFF);
		// shared enable follows the capture side now
		xfer(1'b1, ADDR_CC_ENABLE, 8'h08);
		pulse(5'h10, 4'h0, 2'h0);
		chk("cmp5 off", cc_irq, 32'h0000_0000);
		pulse(5'h00, 4'h8, 2'h0);
		chk("cap4 irq", cc_irq, 32'h0000_0001);
		pulse(5'h01, 4'h7, 2'h0);
		rdc("all flags", ADDR_CC_FLAGS, 8'hFF, 8'hFF);
		xfer(1'b1, ADDR_CC_FLAGS, 8'hFF);
		chk("irq clear", cc_irq, 32'h0000_0000);
		xfer(1'b1, ADDR_CC_ENABLE, 8'h80);
		pulse(5'h01, 4'h0, 2'h0);
		chk("cmp1 irq", cc_irq, 32'h0000_0001);
		pulse(5'h00, 4'h0, 2'h3);
		rdc("flags2", ADDR_OVF_FLAGS, 8'h30, 8'h3F);
		chk("accum irq", acc_irq, 32'h0000_0001);
		// period measured between rises, clears at arbitrary points
		xfer(1'b1, ADDR_OVF_FLAGS, 8'h40);
		wait_hi(1, 200);
		t1 = cyc;
		xfer(1'b1, ADDR_OVF_FLAGS, 8'h40);
		wait_hi(1, 200);
		chk("period", cyc - t1, PRD * 2);
		// special mode lifts the lock; divide by one for the wrap
		xfer(1'b1, ADDR_MODE_CONFIG, 8'h01);
		// divide by sixteen, reachable after the first write only with the lock lifted
		xfer(1'b1, ADDR_OVF_ENABLE, 8'hF3);
		wait_hi(0, 40);
		wait_hi(0, 40);
		chk("div16 gap", n, 32'h0000_0010);
		xfer(1'b1, ADDR_OVF_ENABLE, 8'hF0);
		rdc("unlocked", ADDR_OVF_ENABLE, 8'hF0, 8'hFF);
		xfer(1'b1, ADDR_OVF_FLAGS, 8'h80);
		wait_hi(2, 70000);
		repeat (3) @(posedge core_clk);
		rdc("overflow", ADDR_OVF_FLAGS, 8'h80, 8'h80);
		chk("ovf irq", ovf_irq, 32'h0000_0001);
		xfer(1'b1, ADDR_OVF_ENABLE, 8'h70);
		chk("ovf masked", ovf_irq, 32'h0000_0000);
		give_verdict();
	end
endmodule
